// >>> src/flash_erase_dev.sv
// Flash device end: erase command decoder and self-timed erase engine
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module flash_erase_dev (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial link
    spi_erase_if.dev lnk,
    // Device configuration
    input wire logic page_512,
    input wire logic wp_n,
    input wire logic prot_enable,
    input wire logic [63:0] sector_prot,
    input wire logic [63:0] sector_lock,
    input wire logic fail_inject,
    // Block content port
    input wire logic mark_wr,
    input wire logic [9:0] mark_block,
    input wire logic [9:0] rd_block,
    output logic [7:0] rd_data,
    // Status flags
    output logic ready,
    output logic erase_program_error_flag
);
    import flash_erase_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Sector that owns a block; 0a and 0b both map to 0
    function automatic logic [5:0] sector_of(input logic [9:0] blk);
        sector_of = blk[9:4];
    endfunction

    // Byte match against the chip erase sequence
    function automatic logic chip_byte_ok(input logic [1:0] idx,
                                          input logic [7:0] b);
        case (idx)
            2'd0: chip_byte_ok = (b == CHIP_SEQ_0);
            2'd1: chip_byte_ok = (b == CHIP_SEQ_1);
            2'd2: chip_byte_ok = (b == CHIP_SEQ_2);
            default: chip_byte_ok = (b == CHIP_SEQ_3);
        endcase
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [2:0] sck_sync_q; // Serial clock synchroniser and edge stage
    logic [2:0] cs_sync_q; // Select synchroniser and edge stage
    logic [1:0] si_sync_q; // Data synchroniser, aligned with clock
    logic [1:0] wp_sync_q; // Write protect synchroniser
    logic sck_rise; // Sampling edge of the serial clock
    logic cs_rise; // End of a frame
    logic [7:0] rx_byte; // Byte completed on this edge
    logic [6:0] shift_q; // Partial byte
    logic [2:0] bit_cnt_q; // Bit position within the byte
    logic [2:0] byte_cnt_q; // Whole bytes, saturating
    logic [7:0] op_q; // First byte of the frame
    logic [23:0] addr_q; // Three address bytes
    logic chip_ok_q; // Every byte so far, up to the fourth, matched the chip sequence
    logic [9:0] field; // Ten-bit page field for the current mode
    logic frame_whole; // Frame ended on a byte edge with an address
    logic busy_q; // Erase engine running
    logic [9:0] cur_blk_q; // Block being erased
    logic [9:0] last_blk_q; // Final block of the operation
    logic [15:0] cyc_q; // Cycles spent on the current block
    logic epe_q; // Erase failure seen
    logic wp_eff_q; // Write protect level in force
    logic [1023:0] blank_q; // One erased flag per eight-page block
    logic start; // Accepted command this cycle
    logic [9:0] start_first; // First block of accepted command
    logic [9:0] start_last; // Last block of accepted command
    logic blk_done; // Current block finishes this cycle

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------

    // Link pins cross two flops before any logic looks at them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sck_sync_q <= 3'h0;
            cs_sync_q <= 3'h7;
            si_sync_q <= 2'h0;
            wp_sync_q <= 2'h3;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], lnk.sck};
            cs_sync_q <= {cs_sync_q[1:0], lnk.cs_n};
            si_sync_q <= {si_sync_q[0], lnk.si};
            wp_sync_q <= {wp_sync_q[0], wp_n};
        end
    end

    // Edges are found on the second and third stages only
    assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2] & ~cs_sync_q[1];
    assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
    assign rx_byte = {shift_q, si_sync_q[1]};

    // ----------------------------------------
    // Frame receiver
    // ----------------------------------------

    // Bit and byte counting; a raised select clears the frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_q <= 7'h00;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
        end else if (cs_sync_q[1]) begin
            // Idle between frames; both counts restart, the partial byte is kept
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            shift_q <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            // Saturate so trailing bytes never wrap the count
            if (bit_cnt_q == 3'h7 && byte_cnt_q != 3'h7) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    // Opcode, address bytes and chip sequence check
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op_q <= 8'h00;
            addr_q <= 24'h00_0000;
            chip_ok_q <= 1'b0;
        end else if (sck_rise && bit_cnt_q == 3'h7) begin
            // Bytes beyond the fourth are dropped here
            case (byte_cnt_q)
                3'h0: begin
                    op_q <= rx_byte;
                    chip_ok_q <= chip_byte_ok(2'd0, rx_byte);
                end
                3'h1: begin
                    addr_q[23:16] <= rx_byte;
                    chip_ok_q <= chip_ok_q & chip_byte_ok(2'd1, rx_byte);
                end
                3'h2: begin
                    addr_q[15:8] <= rx_byte;
                    chip_ok_q <= chip_ok_q & chip_byte_ok(2'd2, rx_byte);
                end
                3'h3: begin
                    addr_q[7:0] <= rx_byte;
                    chip_ok_q <= chip_ok_q & chip_byte_ok(2'd3, rx_byte);
                end
                default: begin
                    // Trailing data is ignored
                    chip_ok_q <= chip_ok_q;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Command decode at select release
    // ----------------------------------------

    // Ten page bits sit one lower in the binary page mode
    assign field = page_512 ? addr_q[FLD_LSB_512+:10] : addr_q[FLD_LSB_528+:10];
    // Address commands need all three address bytes on a byte edge
    assign frame_whole = (bit_cnt_q == 3'h0) && (byte_cnt_q >= CMD_BYTES);

    // New commands are not taken while an erase runs
    always_comb begin
        start = 1'b0;
        start_first = 10'h000;
        start_last = 10'h000;
        if (cs_rise && !busy_q) begin
            if (chip_ok_q && byte_cnt_q >= CMD_BYTES) begin
                // Whole array, any trailing bits tolerated
                start = 1'b1;
                start_last = LAST_BLOCK;
            end else if (frame_whole && op_q == OP_BLOCK_ERASE) begin
                // One block of eight pages; low page bits unused
                start = 1'b1;
                start_first = field;
                start_last = field;
            end else if (frame_whole && op_q == OP_SECTOR_ERASE) begin
                start = 1'b1;
                if (sector_of(field) != 6'h00) begin
                    // Sectors 1 to 63 hold sixteen blocks each
                    start_first = {sector_of(field), 4'h0};
                    start_last = {sector_of(field), SEC_LAST_SUB};
                end else if (field[0]) begin
                    // Sector 0b: rest of the first sixteen blocks
                    start_first = 10'h001;
                    start_last = {6'h00, SEC_LAST_SUB};
                end else begin
                    // Sector 0a: block zero alone
                    start_first = 10'h000;
                    start_last = 10'h000;
                end
            end
        end
    end

    // ----------------------------------------
    // Erase engine
    // ----------------------------------------

    assign blk_done = busy_q && (cyc_q == 16'(BLOCK_ERASE_CYC - 1));

    // Walks the block range one block per erase period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            cur_blk_q <= 10'h000;
            last_blk_q <= 10'h000;
            cyc_q <= 16'h0000;
        end else if (start) begin
            busy_q <= 1'b1;
            cur_blk_q <= start_first;
            last_blk_q <= start_last;
            cyc_q <= 16'h0000;
        end else if (busy_q) begin
            if (blk_done) begin
                cyc_q <= 16'h0000;
                if (cur_blk_q == last_blk_q) begin
                    busy_q <= 1'b0;
                end else begin
                    cur_blk_q <= cur_blk_q + 10'h001;
                end
            end else begin
                cyc_q <= cyc_q + 16'h0001;
            end
        end
    end

    // Protection level may only change between erases
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wp_eff_q <= 1'b0;
        end else if (!busy_q) begin
            wp_eff_q <= ~wp_sync_q[1];
        end
    end

    // Error flag: cleared by a new erase, a failure in the same cycle wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            epe_q <= 1'b0;
        end else if (blk_done && fail_inject) begin
            epe_q <= 1'b1;
        end else if (start) begin
            epe_q <= 1'b0;
        end
    end

    // Block contents; a guarded sector keeps its data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            blank_q <= '0;
        end else begin
            if (mark_wr) begin
                blank_q[mark_block] <= 1'b0;
            end
            if (blk_done && !sector_lock[sector_of(cur_blk_q)] &&
                !(sector_prot[sector_of(cur_blk_q)] && (prot_enable || wp_eff_q))) begin
                blank_q[cur_blk_q] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Content read, one cycle after the block number
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= FILLED_BYTE;
        end else begin
            rd_data <= blank_q[rd_block] ? ERASED_BYTE : FILLED_BYTE;
        end
    end

    assign ready = ~busy_q;
    assign erase_program_error_flag = epe_q;

endmodule

// >>> src/flash_erase_host.sv
// Host end: register-driven controller that sends erase frames
`timescale 1ns/100ps
module flash_erase_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Software port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    // Serial link
    spi_erase_if.host lnk
);
    import flash_erase_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    host_state_t state_q; // Frame sequencer
    logic [9:0] field_q; // Ten page bits from software
    logic [31:0] shift_q; // Frame bits, msb first
    logic [5:0] bits_q; // Bits still to send
    logic [4:0] tick_q; // Half period counter
    logic half_end; // Half period elapsed
    logic [31:0] frame; // Frame built from a start write
    logic go; // Start written while idle
    logic done; // Frame finished
    logic irq_stat_q; // Sticky done flag
    logic irq_mask_q; // Done interrupt enable
    logic sck_q;
    logic cs_n_q;
    logic si_q;

    assign half_end = (tick_q == 5'(SCK_HALF_CYC - 1));
    assign go = wr && addr == REG_CTRL && wdata[CTRL_START] && state_q == HS_IDLE;

    // Frame contents for each kind and page mode
    always_comb begin
        frame = {CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3};
        case (erase_kind_t'(wdata[CTRL_KIND_LSB +: 2]))
            KIND_BLOCK: begin
                frame = wdata[CTRL_MODE512] ? {OP_BLOCK_ERASE, 2'b00, field_q, 12'h000}
                    : {OP_BLOCK_ERASE, 1'b0, field_q, 13'h0000};
            end
            KIND_SECTOR: begin
                frame = wdata[CTRL_MODE512] ? {OP_SECTOR_ERASE, 2'b00, field_q, 12'h000}
                    : {OP_SECTOR_ERASE, 1'b0, field_q, 13'h0000};
            end
            default: begin
                frame = {CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3};
            end
        endcase
    end

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------

    // Mode 0: data set while clock low, sampled on the rise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= HS_IDLE;
            shift_q <= 32'h0000_0000;
            bits_q <= 6'h00;
            tick_q <= 5'h00;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            si_q <= 1'b0;
        end else begin
            tick_q <= half_end ? 5'h00 : tick_q + 5'h01;
            case (state_q)
                HS_IDLE: begin
                    tick_q <= 5'h00;
                    if (go) begin
                        cs_n_q <= 1'b0;
                        shift_q <= {frame[30:0], 1'b0};
                        si_q <= frame[31];
                        bits_q <= 6'(FRAME_BITS);
                        state_q <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (half_end) begin
                        sck_q <= 1'b1;
                        state_q <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (half_end) begin
                        sck_q <= 1'b0;
                        bits_q <= bits_q - 6'h01;
                        if (bits_q == 6'h01) begin
                            state_q <= HS_END;
                        end else begin
                            si_q <= shift_q[31];
                            shift_q <= {shift_q[30:0], 1'b0};
                            state_q <= HS_LOW;
                        end
                    end
                end
                HS_END: begin
                    // Release select only after the last bit
                    if (half_end) begin
                        cs_n_q <= 1'b1;
                        state_q <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    // Keep select high long enough to be seen
                    if (half_end) begin
                        state_q <= HS_IDLE;
                    end
                end
                default: begin
                    state_q <= HS_IDLE;
                end
            endcase
        end
    end

    assign done = (state_q == HS_END) && half_end;

    // ----------------------------------------
    // Registers
    // ----------------------------------------

    // Page field and interrupt state; a done event beats its clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            field_q <= 10'h000;
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
        end else begin
            if (wr && addr == REG_ADDR) begin
                field_q <= wdata[9:0];
            end
            if (wr && addr == REG_IRQ_MASK) begin
                irq_mask_q <= wdata[IRQ_DONE];
            end
            if (done) begin
                irq_stat_q <= 1'b1;
            end else if (wr && addr == REG_IRQ_STAT && wdata[IRQ_DONE]) begin
                irq_stat_q <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                REG_ADDR: rdata <= {22'h00_0000, field_q};
                REG_STATUS: rdata <= {31'h0000_0000, state_q != HS_IDLE};
                REG_IRQ_STAT: rdata <= {31'h0000_0000, irq_stat_q};
                REG_IRQ_MASK: rdata <= {31'h0000_0000, irq_mask_q};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    assign irq = irq_stat_q & irq_mask_q;
    assign lnk.sck = sck_q;
    assign lnk.cs_n = cs_n_q;
    assign lnk.si = si_q;

endmodule

// >>> src/flash_erase_pkg.sv
// Shared constants and types for the serial flash erase link and its two ends
//
// Operation
// - Block erase 528 mode: 50h, ten page bits
// - Block erase 512 mode: 50h, bits 21-12
// - Block erase clears eight pages, 1024 blocks
// - Chip select release starts block erase
// - Ready flag low while erasing
// - Failed byte sets erase/program error flag
// - 64 sectors, one per 7Ch command
// - Sector fields in 528-byte page mode
// - Sector fields in 512-byte page mode
// - Top six bits pick sector; bit3 splits 0
// - Chip select release starts sector erase
// - Chip erase needs C7h 94h 80h 9Ah
// - Chip erase ignores trailing bits
// - Host releases select after last bit
// - Chip erase skips protected, locked sectors
// - Write protect waits for erase end
// - Erased locations read all ones
package flash_erase_pkg;

    // ----------------------------------------
    // Command bytes
    // ----------------------------------------
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
    localparam logic [7:0] CHIP_SEQ_0 = 8'hC7;
    localparam logic [7:0] CHIP_SEQ_1 = 8'h94;
    localparam logic [7:0] CHIP_SEQ_2 = 8'h80;
    localparam logic [7:0] CHIP_SEQ_3 = 8'h9A;
    localparam logic [2:0] CMD_BYTES = 3'h4;

    // ----------------------------------------
    // Address field layout in the 24 address bits, block limits and read-back byte values
    // ----------------------------------------
    localparam int FLD_LSB_528 = 13;
    localparam int FLD_LSB_512 = 12;
    localparam logic [9:0] LAST_BLOCK = 10'h3FF;
    localparam logic [3:0] SEC_LAST_SUB = 4'hF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] FILLED_BYTE = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCK_PERIOD_NS = 160;
    localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int BLOCK_ERASE_CYC = 64;
    localparam int FRAME_BITS = 32;

    // ----------------------------------------
    // Host register map and fields
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam int CTRL_START = 0;
    localparam int CTRL_KIND_LSB = 1;
    localparam int CTRL_MODE512 = 3;
    localparam int IRQ_DONE = 0;

    // Erase kinds the host can issue
    typedef enum logic [1:0] {
        KIND_BLOCK = 2'b00,
        KIND_SECTOR = 2'b01,
        KIND_CHIP = 2'b10
    } erase_kind_t;

    // Host frame sequencer
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LOW = 3'b001,
        HS_HIGH = 3'b010,
        HS_END = 3'b011,
        HS_GAP = 3'b100
    } host_state_t;

endpackage

// >>> src/spi_erase_if.sv
// Serial link between the erase host controller and the flash device
`timescale 1ns/100ps
interface spi_erase_if;
    logic sck;
    logic cs_n;
    logic si;

    // Host drives every line
    modport host (output sck, output cs_n, output si);
    // Device only listens
    modport dev (input sck, input cs_n, input si);
endinterface

// >>> verification/flash_erase_props.sv
// Checker for the erase link and the device ready flag
`timescale 1ns/100ps
module flash_erase_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link and status
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic ready
);
    import flash_erase_pkg::*;
    logic sck_q; // Link clock one cycle ago
    logic [5:0] bits_q; // Link clock rises in this frame
    logic [16:0] low_q; // Busy cycles so far; wide enough for a chip erase
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // -------------------------------
    // Helper counters
    // -------------------------------
    // Bit count restarts while deselected, so it holds at the release edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sck_q <= 1'b0;
            bits_q <= '0;
            low_q <= '0;
        end else begin
            sck_q <= sck;
            low_q <= ready ? '0 : low_q + 1'b1;
            if (cs_n) bits_q <= '0;
            else if (sck && !sck_q) bits_q <= bits_q + 1'b1;
        end
    end
    // -------------------------------
    // Properties
    // -------------------------------
    sequence s_end; $rose(cs_n); endsequence
    sequence s_busy; $fell(ready); endsequence
    a_frame_len: assert property (s_end |-> bits_q == FRAME_BITS)
        else $error("frame bit count wrong");
    a_sck_idle: assert property (cs_n |-> !sck)
        else $error("link clock high while deselected");
    a_si_hold: assert property (sck && $past(sck) |-> $stable(si))
        else $error("data moved while clock high");
    a_sck_high: assert property ($rose(sck) |-> sck[*8])
        else $error("link clock high phase short");
    a_cs_gap: assert property (s_end |-> cs_n[*3])
        else $error("select gap short");
    a_cs_setup: assert property ($fell(cs_n) |-> !sck[*8])
        else $error("clock rose too soon after select");
    a_start_edge: assert property (s_busy |-> $past(cs_n, 3) && !$past(cs_n, 5))
        else $error("busy not tied to select release");
    a_busy_len: assert property ($rose(ready) |-> low_q >= BLOCK_ERASE_CYC)
        else $error("busy shorter than one block");
endmodule

// >>> verification/tb.sv
// Self-checking bench for the erase host and device pair
`timescale 1ns/100ps
module tb;
    import flash_erase_pkg::*;
    logic clk_sys = 0;
    logic rst = 1;
    // Software port
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 0;
    logic rd = 0;
    logic [31:0] rdata;
    logic irq;
    // Device side
    logic page_512 = 0;
    logic wp_n = 1;
    logic [63:0] sector_prot = '0;
    logic [63:0] sector_lock = '0;
    logic fail_inject = 0;
    logic mark_wr = 0;
    logic [9:0] mark_block = '0;
    logic [9:0] rd_block = '0;
    logic [7:0] rd_data;
    logic ready;
    logic erase_program_error_flag;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h2ef7_f2ec;
    logic [31:0] r;
    logic [9:0] b, lo, hi, f;
    spi_erase_if lnk ();
    flash_erase_host i_flash_erase_host (.clk_sys(clk_sys), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .lnk(lnk.host));
    flash_erase_dev i_flash_erase_dev (.clk_sys(clk_sys), .rst(rst), .lnk(lnk.dev),
        .page_512(page_512), .wp_n(wp_n), .prot_enable(1'b0), .sector_prot(sector_prot),
        .sector_lock(sector_lock), .fail_inject(fail_inject), .mark_wr(mark_wr),
        .mark_block(mark_block), .rd_block(rd_block), .rd_data(rd_data), .ready(ready),
        .erase_program_error_flag(erase_program_error_flag));
    flash_erase_props i_flash_erase_props (.clk_sys(clk_sys), .rst(rst), .sck(lnk.sck),
        .cs_n(lnk.cs_n), .si(lnk.si), .ready(ready));
    always #2.5 clk_sys = ~clk_sys;
    // Repeatable random source
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard: the chip erase alone is some 66000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 cmp(rdata, e);
    endtask
    task automatic mark(input logic [9:0] k);
        @(posedge clk_sys);
        mark_block <= k;
        mark_wr <= 1'b1;
        @(posedge clk_sys);
        mark_wr <= 1'b0;
    endtask
    task automatic chk(input logic [9:0] k, input logic [7:0] e);
        @(posedge clk_sys);
        rd_block <= k;
        repeat (2) @(posedge clk_sys);
        #1 cmp(rd_data, e);
    endtask
    // One erase through the registers, then wait out the device
    task automatic erase(input erase_kind_t kind, input logic m, input logic [9:0] fa);
        @(posedge clk_sys);
        page_512 <= m;
        wreg(REG_IRQ_STAT, 32'h1);
        wreg(REG_ADDR, {22'h0, fa});
        wreg(REG_CTRL, {28'h0, m, kind, 1'b1});
        rreg(REG_STATUS, 32'h1);
        for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
        cmp(ready, 0);
        for (int i = 0; i < 70000 && ready !== 1'b1; i++) @(posedge clk_sys);
        cmp(ready, 1);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        wreg(REG_IRQ_MASK, 32'h1);
        // Block erase: both ends of the range, then a random block
        for (int k = 0; k < 3; k++) begin
            r = xs();
            b = (k == 0) ? 10'h0 : (k == 1) ? LAST_BLOCK : r[9:0];
            mark(b - 1'b1);
            mark(b);
            mark(b + 1'b1);
            erase(KIND_BLOCK, k[0], b);
            chk(b, ERASED_BYTE);
            chk(b + 1'b1, FILLED_BYTE);
            chk(b - 1'b1, FILLED_BYTE);
        end
        // Interrupt raised, masked and cleared; unmapped read
        rreg(REG_IRQ_STAT, 32'h1);
        cmp(irq, 1);
        wreg(REG_IRQ_MASK, 32'h0);
        #1 cmp(irq, 0);
        wreg(REG_IRQ_MASK, 32'h1);
        wreg(REG_IRQ_STAT, 32'h1);
        rreg(REG_IRQ_STAT, 32'h0);
        rreg(8'h20, 32'h0);
        // Sector erase: 0a, 0b, then a random sector 1 to 63
        for (int k = 0; k < 3; k++) begin
            r = xs();
            b = {4'h0, 6'(r[5:0] % 63 + 1)};
            f = (k < 2) ? 10'(k) : {b[5:0], r[9:6]};
            lo = (k < 2) ? 10'(k) : {b[5:0], 4'h0};
            hi = (k == 0) ? 10'h0 : {f[9:4], SEC_LAST_SUB};
            mark(lo - 1'b1);
            mark(lo);
            mark(hi);
            mark(hi + 1'b1);
            erase(KIND_SECTOR, k[0], f);
            chk(lo, ERASED_BYTE);
            chk(hi, ERASED_BYTE);
            chk(hi + 1'b1, FILLED_BYTE);
            chk(lo - 1'b1, FILLED_BYTE);
        end
        // Error flag set by a failing erase, cleared by a clean one
        @(posedge clk_sys);
        fail_inject <= 1'b1;
        erase(KIND_BLOCK, 1'b0, 10'(xs()));
        cmp(erase_program_error_flag, 1);
        @(posedge clk_sys);
        fail_inject <= 1'b0;
        erase(KIND_BLOCK, 1'b1, 10'(xs()));
        cmp(erase_program_error_flag, 0);
        // Chip erase: locked sector kept, protect asserted mid-erase too late
        @(posedge clk_sys);
        sector_lock[2] <= 1'b1;
        sector_prot[3] <= 1'b1;
        mark(10'h20);
        mark(10'h30);
        mark(LAST_BLOCK);
        fork
            erase(KIND_CHIP, 1'b0, 10'h0);
            begin
                repeat (2000) @(posedge clk_sys);
                wp_n <= 1'b0;
            end
        join
        chk(10'h20, FILLED_BYTE);
        chk(10'h30, ERASED_BYTE);
        chk(LAST_BLOCK, ERASED_BYTE);
        // Protect now in force keeps a sector
        mark(10'h30);
        erase(KIND_BLOCK, 1'b1, 10'h30);
        chk(10'h30, FILLED_BYTE);
        results();
    end
endmodule
